// *** rtl/lrtc_core.sv ***
`timescale 1ns/1ps
// Behaviour
// R1 - 32-bit count increments on each counter tick while running
// R2 - counter tick from 32.768kHz source, divided to 1.024kHz or 1Hz
// R3 - enable bit 0 of control starts counting after crossing into counter domain
// R4 - no counting while period is zero, even when enabled
// R5 - count equal to period loads zero next tick and sets overflow flag
// R6 - count equal to compare sets compare flag next tick, interrupt if enabled
// R7 - compare above period never gives compare request or event
// R8 - events every third match at period 0, every second at 1
// R9 - flags clear on vector execution or on writing one
// R10 - two-bit level fields enable interrupts and set priority
// R11 - capture bit copies count to bus side, self-clears after eight cycles
// R12 - sync busy set while control or count write is crossing
// R13 - top count byte write loads new count within 12 cycles
// R14 - count byte writes ignored while sync busy
// R15 - period writes only taken with enable and sync busy both zero
// R16 - top count byte write blocks flags and wake-ups two ticks
// R17 - period byte write blocks overflow flag and wake-up two ticks
// R18 - top compare byte write blocks flags and wake-ups two ticks
// R19 - partner keeps register clock over eight or twelve times tick rate
// R20 - software writes zero to reserved bits
// R21 - period bytes two and three hold bits 23:16 and 31:24
// R22 - overflow vector at offset 0x00, compare vector at 0x02
// R23 - value bytes ordered low byte first
// R24 - overflow and compare wake-up outputs on matches
module lrtc_core #(
  parameter int ADDR_W = lrtc_pkg::ADDR_W,
  parameter int DIV_FAST = lrtc_pkg::XTAL_HZ / lrtc_pkg::FAST_HZ,
  parameter int DIV_SLOW = lrtc_pkg::XTAL_HZ / lrtc_pkg::SLOW_HZ
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic xtal_in,
  input wire logic vector_ack,
  input wire logic [7:0] vector_ack_ofs,
  output lrtc_pkg::lrtc_irq_type irq_out,
  output lrtc_pkg::lrtc_evt_type evt_out
);

  localparam int DIV_W = $clog2(DIV_SLOW + 1);

  logic xtal_s1_ff, xtal_s2_ff, xtal_s3_ff;
  logic xtal_rise;
  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] div_lim;
  logic tick_ff;
  logic clk_sel_ff;
  logic aw_held_ff, w_held_ff, awready_ff, wready_ff, bvalid_ff;
  logic [1:0] bresp_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [7:0] wdata_ff;
  logic wstrb_ff;
  logic arready_ff, rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic wr_do, wr_map, wr_en, rd_map;
  logic [4:0] wr_idx, rd_idx;
  logic [7:0] nxt_rd_byte;
  logic ctrl_en_ff, en_run_ff;
  logic [3:0] lvl_ff;
  logic [3:0] busy_cnt_ff, cap_cnt_ff;
  logic ctrl_pend_ff, cnt_pend_ff;
  logic sync_busy, sync_apply, cap_busy;
  logic ctrl_wr, cnt_wr, cnt_launch, per_try, per_wr, cmp_hi_wr, cap_start, cnt_load;
  logic [31:0] cnt_ff, cnt_stage_ff, cnt_view_ff, per_ff, cmp_ff;
  logic [1:0] sup_all_ff, sup_ovf_ff;
  logic run, ovf_match, cmp_match;
  logic [1:0] hit_set, flag_clr, evt_mod;
  logic [1:0] flag_ff, req_ff, evt_ff, wake_ff;
  logic [1:0] evt_div_ff [2];

  // crystal edge seen through two flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xtal_s1_ff <= 1'h0;
      xtal_s2_ff <= 1'h0;
      xtal_s3_ff <= 1'h0;
    end else begin
      xtal_s1_ff <= xtal_in;
      xtal_s2_ff <= xtal_s1_ff;
      xtal_s3_ff <= xtal_s2_ff;
    end
  end
  assign xtal_rise = xtal_s2_ff & ~xtal_s3_ff;

  // R2 crystal prescaler
  assign div_lim = clk_sel_ff ? DIV_W'(DIV_SLOW - 1) : DIV_W'(DIV_FAST - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_ff <= '0;
      tick_ff <= 1'h0;
    end else begin
      tick_ff <= 1'h0;
      if (xtal_rise) begin
        if (div_ff >= div_lim) begin
          div_ff <= '0;
          tick_ff <= 1'h1;
        end else begin
          div_ff <= div_ff + DIV_W'(1);
        end
      end
    end
  end

  // bus write side: address and data taken in either order
  assign wr_do = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign wr_idx = awaddr_ff[6:2];
  assign wr_map = (awaddr_ff[ADDR_W-1:7] == '0) && (wr_idx <= lrtc_pkg::IDX_LAST);
  assign wr_en = wr_do & wr_map & wstrb_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'h0;
      w_held_ff <= 1'h0;
      awready_ff <= 1'h1;
      wready_ff <= 1'h1;
      bvalid_ff <= 1'h0;
      bresp_ff <= lrtc_pkg::RESP_OKAY;
      awaddr_ff <= '0;
      wdata_ff <= lrtc_pkg::BYTE_RST;
      wstrb_ff <= 1'h0;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        awaddr_ff <= s_axi_awaddr;
        aw_held_ff <= 1'h1;
        awready_ff <= 1'h0;
      end
      if (s_axi_wvalid && wready_ff) begin
        wdata_ff <= s_axi_wdata[7:0];
        wstrb_ff <= s_axi_wstrb[0];
        w_held_ff <= 1'h1;
        wready_ff <= 1'h0;
      end
      if (wr_do) begin
        aw_held_ff <= 1'h0;
        w_held_ff <= 1'h0;
        bvalid_ff <= 1'h1;
        bresp_ff <= wr_map ? lrtc_pkg::RESP_OKAY : lrtc_pkg::RESP_SLVERR;
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'h0;
        awready_ff <= 1'h1;
        wready_ff <= 1'h1;
      end
    end
  end

  // read mux; R23 low byte first within each value
  assign rd_idx = s_axi_araddr[6:2];
  assign rd_map = (s_axi_araddr[ADDR_W-1:7] == '0) && (rd_idx <= lrtc_pkg::IDX_LAST);
  always_comb begin
    nxt_rd_byte = lrtc_pkg::BYTE_RST;
    if (rd_map) begin
      case (rd_idx[4:2])
        lrtc_pkg::GRP_CNT: nxt_rd_byte = cnt_view_ff[8*rd_idx[1:0] +: 8];
        lrtc_pkg::GRP_PER: nxt_rd_byte = per_ff[8*rd_idx[1:0] +: 8];
        lrtc_pkg::GRP_CMP: nxt_rd_byte = cmp_ff[8*rd_idx[1:0] +: 8];
        default: begin
          case (rd_idx)
            lrtc_pkg::IDX_CTRL: nxt_rd_byte = {7'h00, ctrl_en_ff};
            lrtc_pkg::IDX_SYNC: nxt_rd_byte = {3'h0, cap_busy, 3'h0, sync_busy};
            lrtc_pkg::IDX_LVL: nxt_rd_byte = {4'h0, lvl_ff};
            lrtc_pkg::IDX_FLAG: nxt_rd_byte = {6'h00, flag_ff};
            lrtc_pkg::IDX_CLKSEL: nxt_rd_byte = {7'h00, clk_sel_ff};
            default: nxt_rd_byte = lrtc_pkg::BYTE_RST;
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'h1;
      rvalid_ff <= 1'h0;
      rresp_ff <= lrtc_pkg::RESP_OKAY;
      rdata_ff <= lrtc_pkg::WORD_RST;
    end else begin
      if (s_axi_arvalid && arready_ff) begin
        arready_ff <= 1'h0;
        rvalid_ff <= 1'h1;
        rdata_ff <= {24'h00_0000, nxt_rd_byte};
        rresp_ff <= rd_map ? lrtc_pkg::RESP_OKAY : lrtc_pkg::RESP_SLVERR;
      end
      if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'h0;
        arready_ff <= 1'h1;
      end
    end
  end

  // write decode
  assign ctrl_wr = wr_en && (wr_idx == lrtc_pkg::IDX_CTRL);
  assign cnt_wr = wr_en && (wr_idx[4:2] == lrtc_pkg::GRP_CNT) && !sync_busy;
  assign cnt_launch = cnt_wr && (wr_idx[1:0] == lrtc_pkg::BYTE_HI);
  assign per_try = wr_en && (wr_idx[4:2] == lrtc_pkg::GRP_PER);
  // R15 period only while disabled and idle
  assign per_wr = per_try && !ctrl_en_ff && !sync_busy;
  assign cmp_hi_wr = wr_en && (wr_idx == {lrtc_pkg::GRP_CMP, lrtc_pkg::BYTE_HI});
  assign cap_start = wr_en && (wr_idx == lrtc_pkg::IDX_SYNC) && !cap_busy &&
                     wdata_ff[lrtc_pkg::SYNC_CAP_BIT];

  // R10 levels, clock select and software enable view
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_en_ff <= 1'h0;
      lvl_ff <= lrtc_pkg::LVL_RST;
      clk_sel_ff <= 1'h0;
    end else begin
      if (ctrl_wr) ctrl_en_ff <= wdata_ff[lrtc_pkg::CTRL_EN_BIT];
      if (wr_en && wr_idx == lrtc_pkg::IDX_LVL) lvl_ff <= wdata_ff[3:0];
      if (wr_en && wr_idx == lrtc_pkg::IDX_CLKSEL) begin
        clk_sel_ff <= wdata_ff[lrtc_pkg::CLKSEL_SLOW_BIT];
      end
    end
  end

  // R12 busy window models the crossing into the counter domain
  assign sync_busy = (busy_cnt_ff != 4'h0);
  assign sync_apply = (busy_cnt_ff == 4'h1);
  assign cnt_load = sync_apply && cnt_pend_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_cnt_ff <= 4'h0;
      ctrl_pend_ff <= 1'h0;
      cnt_pend_ff <= 1'h0;
      en_run_ff <= 1'h0;
    end else begin
      if (sync_busy) busy_cnt_ff <= busy_cnt_ff - 4'h1;
      if (sync_apply) begin
        ctrl_pend_ff <= 1'h0;
        cnt_pend_ff <= 1'h0;
      end
      // R3 enable reaches the counter after the crossing
      if (sync_apply && ctrl_pend_ff) en_run_ff <= ctrl_en_ff;
      // R13 count launch gives the longest window
      if (cnt_launch) begin
        busy_cnt_ff <= lrtc_pkg::CNT_WR_SYNC_CYCLES;
        cnt_pend_ff <= 1'h1;
      end else if (ctrl_wr && busy_cnt_ff < lrtc_pkg::CTRL_SYNC_CYCLES) begin
        busy_cnt_ff <= lrtc_pkg::CTRL_SYNC_CYCLES;
      end
      if (ctrl_wr) ctrl_pend_ff <= 1'h1;
    end
  end

  // R11 count capture into the bus-side copy
  assign cap_busy = (cap_cnt_ff != 4'h0);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_cnt_ff <= 4'h0;
      cnt_view_ff <= lrtc_pkg::WORD_RST;
    end else if (cap_start) begin
      cap_cnt_ff <= lrtc_pkg::CAPTURE_CYCLES;
    end else if (cap_busy) begin
      cap_cnt_ff <= cap_cnt_ff - 4'h1;
      if (cap_cnt_ff == 4'h1) cnt_view_ff <= cnt_ff;
    end
  end

  // R14 staged count bytes, blocked while busy; R21 period bytes 2 and 3
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_stage_ff <= lrtc_pkg::WORD_RST;
      per_ff <= lrtc_pkg::WORD_RST;
      cmp_ff <= lrtc_pkg::WORD_RST;
    end else begin
      if (cnt_wr) cnt_stage_ff[8*wr_idx[1:0] +: 8] <= wdata_ff;
      if (per_wr) per_ff[8*wr_idx[1:0] +: 8] <= wdata_ff;
      if (wr_en && wr_idx[4:2] == lrtc_pkg::GRP_CMP) cmp_ff[8*wr_idx[1:0] +: 8] <= wdata_ff;
    end
  end

  // R16 R17 R18 two-tick blocking windows
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sup_all_ff <= 2'h0;
      sup_ovf_ff <= 2'h0;
    end else begin
      if (cnt_launch || cnt_load || cmp_hi_wr) sup_all_ff <= lrtc_pkg::SUPPRESS_TICKS;
      else if (tick_ff && sup_all_ff != 2'h0) sup_all_ff <= sup_all_ff - 2'h1;
      if (per_wr) sup_ovf_ff <= lrtc_pkg::SUPPRESS_TICKS;
      else if (tick_ff && sup_ovf_ff != 2'h0) sup_ovf_ff <= sup_ovf_ff - 2'h1;
    end
  end

  // R4 needs enable and nonzero period
  assign run = en_run_ff && (per_ff != lrtc_pkg::WORD_RST);
  assign ovf_match = (cnt_ff == per_ff);
  // R7 compare beyond period is never a match
  assign cmp_match = (cnt_ff == cmp_ff) && (cmp_ff <= per_ff);

  // R1 R5 count with wrap, new count load wins over a tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= lrtc_pkg::WORD_RST;
    end else if (cnt_load) begin
      cnt_ff <= cnt_stage_ff;
    end else if (tick_ff && run) begin
      cnt_ff <= ovf_match ? lrtc_pkg::WORD_RST : cnt_ff + 32'h0000_0001;
    end
  end

  // R5 R6 flags set on the tick that leaves the matching count
  assign hit_set[lrtc_pkg::FLAG_OVF_BIT] = tick_ff && run && ovf_match && !cnt_load &&
                                           sup_all_ff == 2'h0 && sup_ovf_ff == 2'h0;
  assign hit_set[lrtc_pkg::FLAG_CMP_BIT] = tick_ff && run && cmp_match && !cnt_load &&
                                           sup_all_ff == 2'h0;
  // R9 R22 clear by vector execution or by writing one
  assign flag_clr[lrtc_pkg::FLAG_OVF_BIT] =
      (vector_ack && vector_ack_ofs == lrtc_pkg::VEC_OVF_OFS) ||
      (wr_en && wr_idx == lrtc_pkg::IDX_FLAG && wdata_ff[lrtc_pkg::FLAG_OVF_BIT]);
  assign flag_clr[lrtc_pkg::FLAG_CMP_BIT] =
      (vector_ack && vector_ack_ofs == lrtc_pkg::VEC_CMP_OFS) ||
      (wr_en && wr_idx == lrtc_pkg::IDX_FLAG && wdata_ff[lrtc_pkg::FLAG_CMP_BIT]);
  // R8 events thinned when the period is too short to cross cleanly
  assign evt_mod = (per_ff == 32'h0000_0000) ? 2'h2 :
                   (per_ff == 32'h0000_0001) ? 2'h1 : 2'h0;

  for (genvar i = 0; i < 2; i++) begin : g_src
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        flag_ff[i] <= 1'h0;
        req_ff[i] <= 1'h0;
        wake_ff[i] <= 1'h0;
        evt_ff[i] <= 1'h0;
        evt_div_ff[i] <= 2'h0;
      end else begin
        // set wins over a clear in the same cycle
        flag_ff[i] <= (flag_ff[i] & ~flag_clr[i]) | hit_set[i];
        // R10 request while flag set and level nonzero
        req_ff[i] <= flag_ff[i] && (lvl_ff[2*i +: 2] != 2'h0);
        // R24 wake-up pulse on each accepted match
        wake_ff[i] <= hit_set[i];
        evt_ff[i] <= 1'h0;
        if (hit_set[i]) begin
          if (evt_div_ff[i] >= evt_mod) begin
            evt_div_ff[i] <= 2'h0;
            evt_ff[i] <= 1'h1;
          end else begin
            evt_div_ff[i] <= evt_div_ff[i] + 2'h1;
          end
        end
      end
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign irq_out.comp_level = lvl_ff[3:2];
  assign irq_out.ovf_level = lvl_ff[1:0];
  assign irq_out.comp_req = req_ff[1];
  assign irq_out.ovf_req = req_ff[0];
  assign evt_out.comp_event = evt_ff[1];
  assign evt_out.ovf_event = evt_ff[0];
  assign evt_out.comp_wake = wake_ff[1];
  assign evt_out.ovf_wake = wake_ff[0];

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // R1 step by one
  a_cnt_step: assert property ( // R1
    (tick_ff && run && !ovf_match && !cnt_load) |=> (cnt_ff == $past(cnt_ff) + 32'h0000_0001))
    else $error("count did not step by one");
  // R4 held when stopped
  a_cnt_hold: assert property ( // R4
    (!run && !cnt_load) |=> $stable(cnt_ff)) else $error("count moved while stopped");
  // R5 wrap to zero
  a_cnt_wrap: assert property ( // R5
    (hit_set[0]) |=> (cnt_ff == 32'h0000_0000) && flag_ff[0])
    else $error("overflow did not wrap and flag");
  // R7 compare gate
  a_cmp_gate: assert property ( // R7
    (cmp_ff > per_ff) |-> !hit_set[1] && !evt_ff[1] ##1 !evt_ff[1])
    else $error("compare hit above period");
  // R9 vector clears flag
  a_flag_clear: assert property ( // R9
    (vector_ack && vector_ack_ofs == lrtc_pkg::VEC_CMP_OFS && !hit_set[1]) |=> !flag_ff[1])
    else $error("compare flag not cleared by vector");
  // R10 request follows flag
  a_irq_req: assert property ( // R10
    (flag_ff[0] && lvl_ff[1:0] != 2'h0) |=> req_ff[0]) else $error("overflow request missing");
  // R11 capture timing
  a_cap_time: assert property ( // R11
    cap_start |=> cap_busy [*8] ##1 !cap_busy) else $error("capture not eight cycles");
  // R12 busy after control write
  a_busy_ctrl: assert property ( // R12
    ctrl_wr |=> sync_busy) else $error("no busy after control write");
  // R13 count load time
  a_cnt_sync: assert property ( // R13
    cnt_launch |-> ##12 cnt_load) else $error("count load not at twelve cycles");
  // R14 blocked count writes
  a_cnt_block: assert property ( // R14
    (wr_en && wr_idx[4:2] == lrtc_pkg::GRP_CNT && sync_busy) |=> $stable(cnt_stage_ff))
    else $error("count write taken while busy");
  // R15 blocked period writes
  a_per_block: assert property ( // R15
    (per_try && (ctrl_en_ff || sync_busy)) |=> $stable(per_ff))
    else $error("period write taken while blocked");
  // R16 R18 blocking window
  a_suppress: assert property ( // R16
    (sup_all_ff != 2'h0) |-> (hit_set == 2'h0)) else $error("flag set inside window");

  c_overflow: cover property (hit_set[0] ##[1:20] req_ff[0]);
  c_capture: cover property (cap_start ##9 !cap_busy);
  c_cnt_load: cover property (cnt_launch ##12 cnt_load);

endmodule

// *** rtl/lrtc_pkg.sv ***
package lrtc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register indices, byte address is four times the index
  localparam logic [4:0] IDX_CTRL = 5'h00;
  localparam logic [4:0] IDX_SYNC = 5'h01;
  localparam logic [4:0] IDX_LVL = 5'h02;
  localparam logic [4:0] IDX_FLAG = 5'h03;
  localparam logic [4:0] IDX_COUNT_BYTE0 = 5'h04;
  localparam logic [4:0] IDX_PERIOD_BYTE0 = 5'h08;
  localparam logic [4:0] IDX_PERIOD_BYTE2 = 5'h0a;
  localparam logic [4:0] IDX_PERIOD_BYTE3 = 5'h0b;
  localparam logic [4:0] IDX_CMP0 = 5'h0c;
  localparam logic [4:0] IDX_CLKSEL = 5'h10;
  localparam logic [4:0] IDX_LAST = 5'h10;

  // byte groups of the 32-bit values, low byte first
  localparam logic [2:0] GRP_CNT = 3'h1;
  localparam logic [2:0] GRP_PER = 3'h2;
  localparam logic [2:0] GRP_CMP = 3'h3;
  localparam logic [1:0] BYTE_HI = 2'h3;

  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int SYNC_BUSY_BIT = 0;
  localparam int SYNC_CAP_BIT = 4;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CMP_BIT = 1;
  localparam int CLKSEL_SLOW_BIT = 0;

  // reset values
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] LVL_RST = 4'h0;

  // interrupt vector word offsets
  localparam logic [7:0] VEC_OVF_OFS = 8'h00;
  localparam logic [7:0] VEC_CMP_OFS = 8'h02;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // clock rates in Hz
  localparam int ACLK_HZ = 200_000_000;
  localparam int XTAL_HZ = 32768;
  localparam int FAST_HZ = 1024;
  localparam int SLOW_HZ = 1;

  // timing counts in aclk cycles or counter ticks
  localparam logic [3:0] CTRL_SYNC_CYCLES = 4'h4;
  localparam logic [3:0] CNT_WR_SYNC_CYCLES = 4'hc;
  localparam logic [3:0] CAPTURE_CYCLES = 4'h8;
  localparam logic [1:0] SUPPRESS_TICKS = 2'h2;

  typedef struct packed {
    logic [1:0] comp_level;
    logic [1:0] ovf_level;
    logic comp_req;
    logic ovf_req;
  } lrtc_irq_type;

  typedef struct packed {
    logic comp_event;
    logic ovf_event;
    logic comp_wake;
    logic ovf_wake;
  } lrtc_evt_type;

endpackage

// *** verification/lrtc_core_tb.sv ***
`timescale 1ns/1ps
module lrtc_core_tb;
  logic aclk, aresetn, ack_en, xtal_in, vector_ack;
  logic [7:0] s_axi_awaddr, s_axi_araddr, vector_ack_ofs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  lrtc_pkg::lrtc_irq_type irq_out;
  lrtc_pkg::lrtc_evt_type evt_out;
  int n_fail, comparisons, n_oe, n_ow, n_ce, n_cw, n_ack;

  // short dividers keep ticks at 40 aclk cycles with fast select, 80 with slow select
  lrtc_core #(.DIV_FAST(2), .DIV_SLOW(4)) lrtc_core_i (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .xtal_in, .vector_ack,
    .vector_ack_ofs, .irq_out, .evt_out);
  lrtc_far_model lrtc_far_model_i (.aclk, .aresetn, .ack_en, .irq_in(irq_out), .xtal_in,
    .vector_ack, .vector_ack_ofs);

  always #2.5 aclk = ~aclk;

  always @(posedge aclk) begin
    if (evt_out.ovf_event === 1'b1) n_oe++;
    if (evt_out.ovf_wake === 1'b1) n_ow++;
    if (evt_out.comp_event === 1'b1) n_ce++;
    if (evt_out.comp_wake === 1'b1) n_cw++;
    if (vector_ack === 1'b1) n_ack++;
  end

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  task automatic wr(input logic [4:0] idx, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= {1'b0, idx, 2'b00};
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // no cycle count assumed, only the watchdog ends a hung write
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("write response", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask

  task automatic rd(input logic [4:0] idx, output logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= {1'b0, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk("read response", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask

  task automatic rdc(input logic [4:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    rd(idx, d, lrtc_pkg::RESP_OKAY);
    chk($sformatf("register %h", idx), exp, d);
  endtask

  task automatic poll(input logic [4:0] idx, input logic [31:0] mask, input logic [31:0] want);
    logic [31:0] d;
    int t;
    t = 0;
    do begin
      rd(idx, d, lrtc_pkg::RESP_OKAY);
      t++;
    end while ((d & mask) !== want && t < 300);
    chk($sformatf("poll of %h", idx), want, d & mask);
  endtask

  task automatic set_en(input logic [7:0] v);
    wr(lrtc_pkg::IDX_CTRL, v, lrtc_pkg::RESP_OKAY);
    poll(lrtc_pkg::IDX_SYNC, 32'h0000_0001, 32'h0000_0000);
  endtask

  task automatic wcnt(input logic [31:0] v);
    for (int i = 0; i < 4; i++) wr(lrtc_pkg::IDX_COUNT_BYTE0 + 5'(i), v[8*i+:8], 2'h0);
  endtask

  task automatic win(input int k);
    n_oe = 0;
    n_ow = 0;
    n_ce = 0;
    n_cw = 0;
    repeat (1200) @(posedge aclk);
    chk("overflow wakes", 32'h1, 32'(n_ow > 3));
    chk("event spacing", 32'h1, 32'(n_oe * k <= n_ow + 1 && n_oe * k + 1 >= n_ow));
  endtask

  task automatic t_regs;
    logic [31:0] d;
    rdc(lrtc_pkg::IDX_PERIOD_BYTE2, 32'h0000_0000);
    rdc(lrtc_pkg::IDX_PERIOD_BYTE3, 32'h0000_0000);
    wr(lrtc_pkg::IDX_PERIOD_BYTE2, 8'ha5, lrtc_pkg::RESP_OKAY);
    wr(lrtc_pkg::IDX_PERIOD_BYTE3, 8'h5a, lrtc_pkg::RESP_OKAY);
    rdc(lrtc_pkg::IDX_PERIOD_BYTE2, 32'h0000_00a5);
    rdc(lrtc_pkg::IDX_PERIOD_BYTE3, 32'h0000_005a);
    wr(lrtc_pkg::IDX_PERIOD_BYTE2, 8'h00, lrtc_pkg::RESP_OKAY);
    wr(lrtc_pkg::IDX_PERIOD_BYTE3, 8'h00, lrtc_pkg::RESP_OKAY);
    wr(lrtc_pkg::IDX_CLKSEL, 8'h01, lrtc_pkg::RESP_OKAY);
    rdc(lrtc_pkg::IDX_CLKSEL, 32'h0000_0001);
    wr(lrtc_pkg::IDX_CLKSEL, 8'h00, lrtc_pkg::RESP_OKAY);
    rd(5'h11, d, lrtc_pkg::RESP_SLVERR);
    wr(5'h11, 8'hff, lrtc_pkg::RESP_SLVERR);
  endtask

  task automatic t_count;
    wcnt(32'h1122_3344);
    // busy window still open, byte is dropped
    wr(lrtc_pkg::IDX_COUNT_BYTE0, 8'h99, lrtc_pkg::RESP_OKAY);
    poll(lrtc_pkg::IDX_SYNC, 32'h0000_0001, 32'h0000_0000);
    // period is zero, enable alone must not count
    set_en(8'h01);
    repeat (200) @(posedge aclk);
    set_en(8'h00);
    wr(lrtc_pkg::IDX_SYNC, 8'h10, lrtc_pkg::RESP_OKAY);
    rdc(lrtc_pkg::IDX_SYNC, 32'h0000_0010);
    poll(lrtc_pkg::IDX_SYNC, 32'h0000_0010, 32'h0000_0000);
    for (int i = 0; i < 4; i++) rdc(lrtc_pkg::IDX_COUNT_BYTE0 + 5'(i), {24'h0, 8'(8'h44 - 8'(i * 17))});
    wcnt(32'h0000_0000);
    poll(lrtc_pkg::IDX_SYNC, 32'h0000_0001, 32'h0000_0000);
  endtask

  task automatic t_run;
    wr(lrtc_pkg::IDX_PERIOD_BYTE0, 8'h05, lrtc_pkg::RESP_OKAY);
    wr(lrtc_pkg::IDX_CMP0, 8'h03, lrtc_pkg::RESP_OKAY);
    wr(lrtc_pkg::IDX_LVL, 8'h05, lrtc_pkg::RESP_OKAY);
    wr(lrtc_pkg::IDX_CTRL, 8'h01, lrtc_pkg::RESP_OKAY);
    rdc(lrtc_pkg::IDX_SYNC, 32'h0000_0001);
    poll(lrtc_pkg::IDX_FLAG, 32'h0000_0001, 32'h0000_0001);
    chk("overflow request", 32'h3, {29'h0, irq_out.ovf_level, irq_out.ovf_req});
    poll(lrtc_pkg::IDX_FLAG, 32'h0000_0002, 32'h0000_0002);
    chk("compare request", 32'h3, {29'h0, irq_out.comp_level, irq_out.comp_req});
    wr(lrtc_pkg::IDX_PERIOD_BYTE0, 8'h07, lrtc_pkg::RESP_OKAY);
    rdc(lrtc_pkg::IDX_PERIOD_BYTE0, 32'h0000_0005);
    wr(lrtc_pkg::IDX_FLAG, 8'h03, lrtc_pkg::RESP_OKAY);
    rdc(lrtc_pkg::IDX_FLAG, 32'h0000_0000);
    ack_en <= 1'b1;
    n_ack = 0;
    win(1);
    set_en(8'h00);
    repeat (20) @(posedge aclk);
    rdc(lrtc_pkg::IDX_FLAG, 32'h0000_0000);
    chk("vectors taken", 32'h1, 32'(n_ack > 0));
    ack_en <= 1'b0;
  endtask

  task automatic t_far_compare;
    logic [31:0] d;
    wr(lrtc_pkg::IDX_CMP0, 8'h09, lrtc_pkg::RESP_OKAY);
    wr(lrtc_pkg::IDX_FLAG, 8'h03, lrtc_pkg::RESP_OKAY);
    set_en(8'h01);
    win(1);
    chk("compare events", 32'h0, 32'(n_ce));
    chk("compare wakes", 32'h0, 32'(n_cw));
    rd(lrtc_pkg::IDX_FLAG, d, lrtc_pkg::RESP_OKAY);
    chk("compare flag", 32'h0, {31'h0, d[1]});
    set_en(8'h00);
  endtask

  task automatic t_thin;
    wr(lrtc_pkg::IDX_PERIOD_BYTE0, 8'h01, lrtc_pkg::RESP_OKAY);
    wr(lrtc_pkg::IDX_CMP0, 8'h00, lrtc_pkg::RESP_OKAY);
    // stale count above the new period would run to wrap
    wcnt(32'h0000_0000);
    poll(lrtc_pkg::IDX_SYNC, 32'h0000_0001, 32'h0000_0000);
    set_en(8'h01);
    win(2);
    chk("compare wakes", 32'h1, 32'(n_cw > 3));
    set_en(8'h00);
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    ack_en = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_count;
    t_run;
    t_far_compare;
    t_thin;
    report_and_stop;
  end

  // bounded by the longest plausible run of all scenarios
  initial begin
    repeat (60000) @(posedge aclk);
    n_fail++;
    report_and_stop;
  end
endmodule

// *** verification/lrtc_far_model.sv ***
`timescale 1ns/1ps
module lrtc_far_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ack_en,
  input wire lrtc_pkg::lrtc_irq_type irq_in,
  output logic xtal_in,
  output logic vector_ack,
  output logic [7:0] vector_ack_ofs
);
  initial begin
    xtal_in = 1'b0;
    forever #50 xtal_in = ~xtal_in;
  end
  always @(posedge aclk) begin
    vector_ack <= 1'b0;
    // offset is meaningless between acks, so it keeps changing
    vector_ack_ofs <= ~vector_ack_ofs;
    if (!aresetn) begin
      vector_ack_ofs <= 8'h00;
    end else if (ack_en && !vector_ack && irq_in.ovf_req) begin
      vector_ack <= 1'b1;
      vector_ack_ofs <= lrtc_pkg::VEC_OVF_OFS;
    end else if (ack_en && !vector_ack && irq_in.comp_req) begin
      vector_ack <= 1'b1;
      vector_ack_ofs <= lrtc_pkg::VEC_CMP_OFS;
    end
  end
endmodule
